//--- rtl/mts_engine.sv
// address table command engine: learn insert and filtered scan, Avalon-MM slave
// What this block does
// R1 - learn with group kind stores destination as a port-group row pointer
// R2 - pinned entries are never aged or aged out by the engine
// R3 - command 0 with trigger inserts staged entry in the first free row, clears trigger, flags success; a full table flags failure
// R4 - command 5 with trigger starts a scan
// R5 - engine clears the trigger itself when the scan is finished
// R6 - walk rows from start; find-next stops on hit, scan-all modifies hits
// R7 - stop-on-hit bit chooses between find-next and scan-all
// R8 - scan starts at the configured row; row zero covers the whole table
// R9 - software resumes find-next from the row after the hit
// R10 - domain filter matches only the staged filtering domain
// R11 - destination filter compares kind and masked destination value
// R12 - age-port filter keeps only entries of ports selected for aging
// R13 - skip-pinned filter keeps only unpinned entries
// R14 - stale-only filter keeps entries whose counter reached maximum age
// R15 - interval mask selects which aging period classes match
// R16 - counter and relearn filters need equality with staged values
// R17 - hits get inactivity counter rewritten per its select
// R18 - hits get relearn marker rewritten per its select
// R19 - relocate replaces masked destination bits with the new value
// R20 - delete removes hits and raises the removed event
// R21 - software aging removes maxed entries, increments the others
// R22 - report last hit row, hit count, and match-found event
// R23 - software leaves configuration alone while the trigger is set
//
// The Avalon-MM register port and the register addresses were decided locally.
module mts_engine
    import mts_pkg::*;
#(
    parameter int ROWS      = 32,
    parameter int GROUP_W   = 6
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);

    localparam int ROW_W = $clog2(ROWS);

    if (ROWS < 2 || ROWS > 256 || (1 << ROW_W) != ROWS) begin : g_rows_check
        $error("ROWS must be a power of two from 2 to 256");
    end
    if (GROUP_W < 1 || GROUP_W > 12) begin : g_group_check
        $error("GROUP_W must be 1 to 12");
    end

    localparam logic [ROW_W-1:0] LAST_ROW   = ROW_W'(ROWS - 1);
    localparam logic [11:0]      GROUP_MASK = 12'((1 << GROUP_W) - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_INSERT, ST_SCAN} mts_state_t;

    // reset release through two flops
    logic rst_meta_reg;
    logic rst_n_sync;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync   <= rst_meta_reg;
        end
    end

    mts_ctrl_t      ctrl_reg;
    mts_entry_t     staged_reg;
    mts_scan_cfg_t  scan_cfg_reg;
    mts_move_cfg_t  move_cfg_reg;
    logic [31:0]    port_filt_reg;
    logic [ROW_W-1:0] position_reg;
    logic [15:0]    hit_count_reg;
    logic [MTS_EV_W-1:0] events_reg;
    logic [31:0]    readdata_reg;
    logic           waitreq_reg;
    mts_state_t     state_reg;
    logic [ROW_W-1:0] ptr_reg;
    mts_entry_t     table_mem [ROWS];

    // ---------------- bus decode ----------------
    wire        bus_req     = avs_read | avs_write;
    wire        wr_fire     = avs_write & ~waitreq_reg;
    wire [31:0] be_mask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire        hit_ctrl    = avs_address == MTS_OFS_CTRL;
    wire        hit_entry   = avs_address == MTS_OFS_ENTRY;
    wire        hit_scan    = avs_address == MTS_OFS_SCAN_CFG;
    wire        hit_move    = avs_address == MTS_OFS_MOVE_CFG;
    wire        hit_pfilt   = avs_address == MTS_OFS_PORT_FILT;
    wire        hit_pos     = avs_address == MTS_OFS_POSITION;
    wire        hit_cnt     = avs_address == MTS_OFS_HIT_COUNT;
    wire        hit_events  = avs_address == MTS_OFS_EVENTS;
    wire        hit_rowrd   = avs_address == MTS_OFS_ROW_READ;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] lanes,
                                          input logic [31:0] wmask);
        merge = ((old_v & ~lanes) | (new_v & lanes)) & wmask;
    endfunction

    wire [31:0] rd_mux =
        hit_ctrl   ? 32'(ctrl_reg)                          :
        hit_entry  ? 32'(staged_reg)                        :
        hit_scan   ? 32'(scan_cfg_reg)                      :
        hit_move   ? 32'(move_cfg_reg)                      :
        hit_pfilt  ? port_filt_reg                          :
        hit_pos    ? 32'(position_reg)                      :
        hit_cnt    ? 32'(hit_count_reg)                     :
        hit_events ? 32'(events_reg)                        :
        hit_rowrd  ? 32'(table_mem[position_reg])           :
                     MTS_RST_ZERO;

    // one-cycle answer: waitrequest drops the cycle after a request appears
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            waitreq_reg  <= 1'b1;
            readdata_reg <= MTS_RST_ZERO;
        end else begin
            waitreq_reg <= ~(bus_req & waitreq_reg);
            if (avs_read && waitreq_reg) begin
                readdata_reg <= rd_mux;
            end
        end
    end

    assign avs_waitrequest = waitreq_reg;
    assign avs_readdata    = readdata_reg;

    // ---------------- current row evaluation ----------------
    wire mts_entry_t cur = table_mem[ptr_reg];

    wire dom_ok   = ~scan_cfg_reg.domain_match_enable
                  | (cur.entry_filter_domain == staged_reg.entry_filter_domain); // R10
    wire dest_ok  = ~scan_cfg_reg.dest_match_enable
                  | ((cur.entry_dest_kind == staged_reg.entry_dest_kind)
                     && (((cur.entry_dest_value ^ staged_reg.entry_dest_value)
                          & move_cfg_reg.dest_mask) == 12'h000)); // R11
    // low half selects local ports, high half other units, by the low port bits
    wire port_sel = (cur.entry_dest_kind == 2'h0)
                  ? port_filt_reg[{1'b0, cur.entry_dest_value[3:0]}]
                  : port_filt_reg[{1'b1, cur.entry_dest_value[3:0]}];
    wire port_ok  = ~scan_cfg_reg.age_port_select_enable | port_sel; // R12
    wire lock_ok  = ~scan_cfg_reg.skip_pinned_enable | ~cur.entry_pinned; // R13
    wire stale_ok = ~scan_cfg_reg.stale_only_enable
                  | (cur.inactivity == scan_cfg_reg.max_age); // R14
    wire intv_ok  = scan_cfg_reg.interval_select_mask[cur.aging_period_class]; // R15
    wire age_ok   = ~scan_cfg_reg.age_match_enable
                  | (cur.inactivity == staged_reg.inactivity); // R16
    wire rl_ok    = ~scan_cfg_reg.relearn_match_enable
                  | (cur.relearn_marker == staged_reg.relearn_marker); // R16
    wire row_hit  = cur.entry_valid_bit & dom_ok & dest_ok & port_ok & lock_ok
                  & stale_ok & intv_ok & age_ok & rl_ok;

    // ---------------- modification of a hit in scan-all ----------------
    wire [1:0] age_sel_v =
        (scan_cfg_reg.age_rewrite_select == MTS_SEL_CLR) ? 2'h0                 :
        (scan_cfg_reg.age_rewrite_select == MTS_SEL_SET) ? scan_cfg_reg.max_age :
                                                           cur.inactivity; // R17
    wire       rl_sel_v  =
        (scan_cfg_reg.relearn_rewrite_select == MTS_SEL_CLR) ? 1'b0 :
        (scan_cfg_reg.relearn_rewrite_select == MTS_SEL_SET) ? 1'b1 :
                                                               cur.relearn_marker; // R18
    wire       sw_age    = scan_cfg_reg.software_aging_enable & ~cur.entry_pinned; // R2
    wire       aged_out  = sw_age & (cur.inactivity == scan_cfg_reg.max_age); // R21
    wire [1:0] age_new   = (sw_age && !aged_out) ? 2'(cur.inactivity + 2'h1)
                                                 : age_sel_v; // R21
    wire       removing  = scan_cfg_reg.delete_hits_enable | aged_out; // R20
    wire [11:0] moved    = (cur.entry_dest_value & ~move_cfg_reg.dest_mask)
                         | (move_cfg_reg.new_dest & move_cfg_reg.dest_mask); // R19

    mts_entry_t modified;
    always_comb begin
        modified                    = cur;
        modified.inactivity         = age_new;
        modified.relearn_marker     = rl_sel_v;
        if (scan_cfg_reg.relocate_enable) begin
            modified.entry_dest_value = moved; // R19
        end
        if (removing) begin
            modified.entry_valid_bit  = 1'b0; // R20
        end
    end

    // staged entry as it goes into the table
    mts_entry_t insert_v;
    always_comb begin
        insert_v = staged_reg;
        if (staged_reg.entry_dest_kind == MTS_KIND_GROUP) begin
            insert_v.entry_dest_value = staged_reg.entry_dest_value & GROUP_MASK; // R1
        end
    end

    // ---------------- engine sequencing ----------------
    wire        start_req  = (state_reg == ST_IDLE) && ctrl_reg.table_op_trigger;
    wire        at_end     = ptr_reg == LAST_ROW;
    wire        ins_free   = (state_reg == ST_INSERT) && !cur.entry_valid_bit;
    wire        ins_fail   = (state_reg == ST_INSERT) && cur.entry_valid_bit && at_end;
    wire        scan_step  = state_reg == ST_SCAN;
    wire        scan_hit   = scan_step && row_hit;
    wire        stop_now   = scan_hit && scan_cfg_reg.stop_on_hit_enable; // R7
    wire        scan_done  = scan_step && (stop_now || at_end);
    wire        bad_cmd    = start_req && (ctrl_reg.cmd != MTS_CMD_LEARN)
                                      && (ctrl_reg.cmd != MTS_CMD_SCAN);
    wire        op_done    = ins_free || ins_fail || scan_done || bad_cmd;
    // find-next only reports, scan-all rewrites every hit
    wire        tbl_wr     = ins_free || (scan_hit && !scan_cfg_reg.stop_on_hit_enable); // R6
    wire mts_entry_t tbl_wdata = ins_free ? insert_v : modified;

    wire [MTS_EV_W-1:0] ev_set;
    assign ev_set[MTS_EV_INSERT_DONE]  = ins_free; // R3
    assign ev_set[MTS_EV_SCAN_REMOVED] = tbl_wr && scan_step && removing; // R20
    assign ev_set[MTS_EV_MATCH_FOUND]  = scan_hit; // R22
    assign ev_set[MTS_EV_INSERT_FAIL]  = ins_fail;
    wire [MTS_EV_W-1:0] ev_clr = (wr_fire && hit_events)
                               ? avs_writedata[MTS_EV_W-1:0] & be_mask[MTS_EV_W-1:0]
                               : '0;

    mts_state_t state_next;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_req && ctrl_reg.cmd == MTS_CMD_LEARN) begin
                    state_next = ST_INSERT; // R3
                end else if (start_req && ctrl_reg.cmd == MTS_CMD_SCAN) begin
                    state_next = ST_SCAN; // R4
                end
            end
            ST_INSERT: begin
                if (ins_free || ins_fail) begin
                    state_next = ST_IDLE;
                end
            end
            ST_SCAN: begin
                if (scan_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    wire [ROW_W-1:0] ptr_next =
        (start_req && ctrl_reg.cmd == MTS_CMD_SCAN) ? ctrl_reg.start_row[ROW_W-1:0] : // R8
        start_req                                   ? '0                            :
        (state_reg != ST_IDLE && !at_end)           ? ROW_W'(ptr_reg + 1'b1)        : // R6
                                                      ptr_reg;

    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_reg <= ST_IDLE;
            ptr_reg   <= '0;
        end else begin
            state_reg <= state_next;
            ptr_reg   <= ptr_next;
        end
    end

    // ---------------- configuration registers ----------------
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            ctrl_reg      <= mts_ctrl_t'(MTS_RST_ZERO);
            staged_reg    <= mts_entry_t'(MTS_RST_ZERO);
            scan_cfg_reg  <= mts_scan_cfg_t'(MTS_RST_ZERO);
            move_cfg_reg  <= mts_move_cfg_t'(MTS_RST_ZERO);
            port_filt_reg <= MTS_RST_PORT_FILT;
        end else begin
            if (wr_fire && hit_ctrl) begin
                ctrl_reg <= mts_ctrl_t'(merge(32'(ctrl_reg), avs_writedata, be_mask,
                                              MTS_CTRL_WMASK));
            end else if (op_done) begin
                ctrl_reg.table_op_trigger <= 1'b0; // R5
            end
            if (wr_fire && hit_entry) begin
                staged_reg <= mts_entry_t'(merge(32'(staged_reg), avs_writedata, be_mask,
                                                 32'hFFFF_FFFF));
            end
            if (wr_fire && hit_scan) begin
                scan_cfg_reg <= mts_scan_cfg_t'(merge(32'(scan_cfg_reg), avs_writedata,
                                                      be_mask, MTS_SCAN_CFG_WMASK));
            end
            if (wr_fire && hit_move) begin
                move_cfg_reg <= mts_move_cfg_t'(merge(32'(move_cfg_reg), avs_writedata,
                                                      be_mask, MTS_MOVE_CFG_WMASK));
            end
            if (wr_fire && hit_pfilt) begin
                port_filt_reg <= merge(port_filt_reg, avs_writedata, be_mask,
                                       32'hFFFF_FFFF);
            end
        end
    end

    // ---------------- status and events ----------------
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            position_reg  <= '0;
            hit_count_reg <= '0;
            events_reg    <= '0;
        end else begin
            // set beats a clear in the same cycle
            events_reg <= (events_reg & ~ev_clr) | ev_set;
            if (start_req && ctrl_reg.cmd == MTS_CMD_SCAN) begin
                hit_count_reg <= '0;
            end else if (scan_hit) begin
                hit_count_reg <= 16'(hit_count_reg + 1'b1); // R22
            end
            if (scan_hit || ins_free) begin
                position_reg <= ptr_reg; // R22
            end
        end
    end

    // ---------------- table storage ----------------
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            table_mem <= '{default: '0};
        end else if (tbl_wr) begin
            table_mem[ptr_reg] <= tbl_wdata; // R3
        end
    end

endmodule

//--- rtl/mts_pkg.sv
// shared types and constants of the address table scan engine
package mts_pkg;

    // register byte offsets
    localparam logic [7:0] MTS_OFS_CTRL      = 8'h00;
    localparam logic [7:0] MTS_OFS_ENTRY     = 8'h04;
    localparam logic [7:0] MTS_OFS_SCAN_CFG  = 8'h08;
    localparam logic [7:0] MTS_OFS_MOVE_CFG  = 8'h0C;
    localparam logic [7:0] MTS_OFS_PORT_FILT = 8'h10;
    localparam logic [7:0] MTS_OFS_POSITION  = 8'h14;
    localparam logic [7:0] MTS_OFS_HIT_COUNT = 8'h18;
    localparam logic [7:0] MTS_OFS_EVENTS    = 8'h1C;
    localparam logic [7:0] MTS_OFS_ROW_READ  = 8'h20;

    // reset values
    localparam logic [31:0] MTS_RST_ZERO      = 32'h0000_0000;
    localparam logic [31:0] MTS_RST_PORT_FILT = 32'hFFFF_FFFF;

    // command codes
    localparam logic [2:0] MTS_CMD_LEARN = 3'h0;
    localparam logic [2:0] MTS_CMD_SCAN  = 3'h5;

    // destination kind of a port-group pointer
    localparam logic [1:0] MTS_KIND_GROUP = 2'h3;

    // rewrite selects for inactivity counter and relearn marker
    localparam logic [1:0] MTS_SEL_KEEP = 2'h0;
    localparam logic [1:0] MTS_SEL_CLR  = 2'h1;
    localparam logic [1:0] MTS_SEL_SET  = 2'h2;

    // sticky event bit positions
    localparam int MTS_EV_INSERT_DONE  = 0;
    localparam int MTS_EV_SCAN_REMOVED = 1;
    localparam int MTS_EV_MATCH_FOUND  = 2;
    localparam int MTS_EV_INSERT_FAIL  = 3;
    localparam int MTS_EV_W            = 4;

    typedef struct packed {
        logic        entry_valid_bit;
        logic        entry_pinned;
        logic [1:0]  entry_dest_kind;
        logic [11:0] entry_dest_value;
        logic [10:0] entry_filter_domain;
        logic [1:0]  inactivity;
        logic [1:0]  aging_period_class;
        logic        relearn_marker;
    } mts_entry_t;

    typedef struct packed {
        logic [13:0] spare_hi;
        logic [1:0]  start_type;
        logic [7:0]  start_row;
        logic [3:0]  spare_lo;
        logic [2:0]  cmd;
        logic        table_op_trigger;
    } mts_ctrl_t;

    typedef struct packed {
        logic [10:0] spare;
        logic [1:0]  max_age;
        logic        software_aging_enable;
        logic        delete_hits_enable;
        logic        relocate_enable;
        logic [1:0]  relearn_rewrite_select;
        logic [1:0]  age_rewrite_select;
        logic [3:0]  interval_select_mask;
        logic        relearn_match_enable;
        logic        age_match_enable;
        logic        stale_only_enable;
        logic        skip_pinned_enable;
        logic        age_port_select_enable;
        logic        dest_match_enable;
        logic        domain_match_enable;
        logic        stop_on_hit_enable;
    } mts_scan_cfg_t;

    typedef struct packed {
        logic [3:0]  spare_hi;
        logic [11:0] dest_mask;
        logic [3:0]  spare_lo;
        logic [11:0] new_dest;
    } mts_move_cfg_t;

    // writable bits of each configuration register; the rest read zero
    localparam logic [31:0] MTS_CTRL_WMASK     = 32'h0003_FF0F;
    localparam logic [31:0] MTS_SCAN_CFG_WMASK = 32'h001F_FFFF;
    localparam logic [31:0] MTS_MOVE_CFG_WMASK = 32'h0FFF_0FFF;

endpackage

//--- sim/mts_engine_sva.sv
// bus timing and status read checks for the address table engine
module mts_engine_chk
    import mts_pkg::*;
#(
    parameter int ROWS = 32
) (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ns;
    // generous margin: a learn walks every row, a scan one row per cycle
    localparam int DONE_LIMIT = ROWS + 8;
    logic [9:0] trig_age_reg;
    wire rd_ans = avs_read && !avs_waitrequest;
    wire trig_take = avs_write && !avs_waitrequest && avs_address == MTS_OFS_CTRL
                     && avs_byteenable[0] && avs_writedata[0];
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) trig_age_reg <= 10'h3FF;
        else if (trig_take) trig_age_reg <= 10'h000;
        else if (trig_age_reg != 10'h3FF) trig_age_reg <= trig_age_reg + 10'h001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered after one wait cycle");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without a request");
    chk_readdata_hold: assert property (rd_ans |=> $stable(avs_readdata))
        else $error("read data changed after the answer");
    chk_unmapped_zero: assert property (rd_ans && avs_address > MTS_OFS_ROW_READ
        |-> avs_readdata == MTS_RST_ZERO) else $error("unmapped read not zero");
    chk_ctrl_spare: assert property (rd_ans && avs_address == MTS_OFS_CTRL
        |-> (avs_readdata & ~MTS_CTRL_WMASK) == 32'h0000_0000) else $error("ctrl spare bits set");
    chk_trigger_done: assert property (rd_ans && avs_address == MTS_OFS_CTRL
        && trig_age_reg > DONE_LIMIT |-> !avs_readdata[0]) else $error("trigger never cleared");
    chk_position_range: assert property (rd_ans && avs_address == MTS_OFS_POSITION
        |-> avs_readdata < ROWS) else $error("position beyond table");
    chk_count_range: assert property (rd_ans && avs_address == MTS_OFS_HIT_COUNT
        |-> avs_readdata <= ROWS) else $error("hit count beyond table size");
    cover property (trig_take && avs_writedata[3:1] == MTS_CMD_LEARN);
    cover property (trig_take && avs_writedata[3:1] == MTS_CMD_SCAN);
    cover property (rd_ans && avs_address > MTS_OFS_ROW_READ);
endmodule

bind mts_engine mts_engine_chk #(.ROWS(ROWS)) u_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

//--- sim/mts_engine_bench.sv
// self-checking bench for the address table engine over its register bus
`define MTS_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module mts_engine_bench
    import mts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ROWS = 8;
    localparam logic [31:0] BASE = 32'h0018_0F00;
    localparam mts_entry_t LRN [4] = '{'{1'b1, 1'b0, 2'h0, 12'h005, 11'h007, 2'h0, 2'h0, 1'b0},
        '{1'b1, 1'b1, 2'h3, 12'hFFF, 11'h007, 2'h0, 2'h0, 1'b0},
        '{1'b1, 1'b0, 2'h0, 12'h005, 11'h009, 2'h3, 2'h1, 1'b0},
        '{1'b1, 1'b0, 2'h0, 12'h006, 11'h007, 2'h2, 2'h2, 1'b1}};
    // group pointer keeps only GROUP_W low bits
    localparam mts_entry_t G1 = '{1'b1, 1'b1, 2'h3, 12'h03F, 11'h007, 2'h0, 2'h0, 1'b0};
    localparam mts_entry_t STG = '{1'b0, 1'b0, 2'h0, 12'h004, 11'h009, 2'h2, 2'h0, 1'b1};
    localparam mts_entry_t AGED [3] = '{'{1'b1, 1'b0, 2'h0, 12'h0A1, 11'h007, 2'h1, 2'h0, 1'b1},
        G1, '{1'b1, 1'b0, 2'h0, 12'h0A2, 11'h007, 2'h3, 2'h2, 1'b1}};
    localparam logic [31:0] FLT_CFG [9] = '{BASE | 32'h0000_0004, BASE | 32'h0000_0010,
        BASE | 32'h0000_0020, 32'h0018_0400, BASE | 32'h0000_0040, BASE | 32'h0000_0080,
        BASE | 32'h0000_0008, BASE | 32'h0000_0002, BASE};
    localparam logic [31:0] FLT_CNT [9] = '{3, 3, 1, 1, 1, 1, 2, 1, 4};
    localparam logic [7:0] RST_ADR [6] = '{MTS_OFS_CTRL, MTS_OFS_SCAN_CFG, MTS_OFS_PORT_FILT,
        MTS_OFS_EVENTS, MTS_OFS_HIT_COUNT, 8'h24};
    localparam logic [31:0] RST_VAL [6] = '{0, 0, MTS_RST_PORT_FILT, 0, 0, 0};
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          n_fail = 0;
    int          samples_checked = 0;
    logic [7:0]  start;

    always #50 ref_clk = ~ref_clk;

    mts_engine #(.ROWS(ROWS), .GROUP_W(6)) DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // read right after the edge: flops have not updated yet, so this is the sampled value
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40) begin
            n_fail++;
            print_verdict();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        `MTS_CHK(q, e)
    endtask
    task automatic wait_done;
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            xfer(1'b0, MTS_OFS_CTRL, 32'h0000_0000, q);
            n++;
        end while (q[0] !== 1'b0 && n < 50);
        `MTS_CHK(q[0], 1'b0)
    endtask
    task automatic scan(input logic [31:0] cfg, input logic [7:0] row);
        wr(MTS_OFS_SCAN_CFG, cfg);
        wr(MTS_OFS_CTRL, {16'h0000, row, 8'h0B});
        wait_done();
    endtask
    task automatic res(input logic [31:0] pos, input logic [31:0] cnt);
        if (cnt != 0) rd_chk(MTS_OFS_POSITION, pos);
        rd_chk(MTS_OFS_HIT_COUNT, cnt);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wr(MTS_OFS_HIT_COUNT, 32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++) rd_chk(RST_ADR[i], RST_VAL[i]);
        for (int i = 0; i < 4; i++) begin
            wr(MTS_OFS_ENTRY, LRN[i]);
            wr(MTS_OFS_CTRL, 32'h0000_0001);
            wait_done();
            rd_chk(MTS_OFS_POSITION, 32'(i));
            rd_chk(MTS_OFS_EVENTS, 32'h0000_0001);
            rd_chk(MTS_OFS_ROW_READ, (i == 1) ? G1 : LRN[i]);
            wr(MTS_OFS_EVENTS, 32'h0000_000F);
        end
        // unknown command: trigger just clears, nothing else moves
        wr(MTS_OFS_CTRL, 32'h0000_0003);
        wait_done();
        rd_chk(MTS_OFS_EVENTS, 32'h0000_0000);
        wr(MTS_OFS_ENTRY, LRN[0]);
        start = 8'h00;
        for (int i = 0; i < 3; i++) begin
            scan(32'h0000_0F03, start);
            res(AGED[i] == G1 ? 32'h1 : 32'(i == 2 ? 3 : 0), 32'h1);
            start = (i == 0) ? 8'h01 : ((i == 1) ? 8'h02 : 8'h04);
        end
        rd_chk(MTS_OFS_EVENTS, 32'h0000_0004);
        scan(32'h0000_0F03, start);
        res(32'h0, 32'h0);
        wr(MTS_OFS_ENTRY, STG);
        wr(MTS_OFS_MOVE_CFG, 32'h0FFC_0000);
        wr(MTS_OFS_PORT_FILT, 32'h0000_0020);
        for (int i = 0; i < 9; i++) begin
            scan(FLT_CFG[i], 8'h00);
            rd_chk(MTS_OFS_HIT_COUNT, FLT_CNT[i]);
        end
        wr(MTS_OFS_MOVE_CFG, 32'h0FFC_00A0);
        scan(BASE | 32'h0001_8004, 8'h00);
        res(32'h3, 32'h3);
        rd_chk(MTS_OFS_ROW_READ, {1'b1, 1'b0, 2'h0, 12'h0A2, 11'h007, 2'h2, 2'h2, 1'b1});
        wr(MTS_OFS_EVENTS, 32'h0000_000F);
        scan(BASE | 32'h0004_0000, 8'h00);
        rd_chk(MTS_OFS_EVENTS, 32'h0000_0006);
        for (int i = 0; i < 3; i++) begin
            scan(32'h0018_0F01, 8'(i));
            res(32'(i == 2 ? 3 : i), 32'h1);
            rd_chk(MTS_OFS_ROW_READ, AGED[i]);
        end
        scan(BASE | 32'h0000_1010, 8'h00);
        res(32'h3, 32'h2);
        rd_chk(MTS_OFS_ROW_READ, {1'b1, 1'b0, 2'h0, 12'h0A2, 11'h007, 2'h0, 2'h2, 1'b1});
        wr(MTS_OFS_EVENTS, 32'h0000_000F);
        scan(BASE | 32'h0002_0000, 8'h00);
        rd_chk(MTS_OFS_EVENTS, 32'h0000_0006);
        scan(BASE, 8'h00);
        res(32'h0, 32'h0);
        print_verdict();
    end
endmodule
